// ---- jtdp_params.svh ----
`ifndef JTDP_PARAMS_SVH
`define JTDP_PARAMS_SVH

// clock rate of both ends
`define JTDP_CLK_MHZ 50

// instruction register layout and codes
`define JTDP_IR_LEN 4
`define JTDP_IR_CAPTURE 4'h1
`define JTDP_INS_BYPASS 4'hF
`define JTDP_INS_IDCODE 4'h2
`define JTDP_INS_USER 4'h8
`define JTDP_INS_DBGREQ 4'h7
`define JTDP_IR_RESET `JTDP_INS_IDCODE

// data register lengths
`define JTDP_ID_LEN 32
`define JTDP_USER_LEN 16
`define JTDP_DR_MAX 32

// device: debug acknowledge pull time
`define JTDP_ACK_NS 1280
`define JTDP_ACK_CYC ((`JTDP_ACK_NS * `JTDP_CLK_MHZ + 999) / 1000)

// host: test clock half period
`define JTDP_TCK_HALF_NS 160
`define JTDP_TCK_HALF_CYC ((`JTDP_TCK_HALF_NS * `JTDP_CLK_MHZ + 999) / 1000)

// host: debug request pull, guard and wait for acknowledge
`define JTDP_REQ_NS 160
`define JTDP_REQ_CYC ((`JTDP_REQ_NS * `JTDP_CLK_MHZ + 999) / 1000)
`define JTDP_GUARD_NS 80
`define JTDP_GUARD_CYC ((`JTDP_GUARD_NS * `JTDP_CLK_MHZ + 999) / 1000)
`define JTDP_WAIT_NS 2000
`define JTDP_WAIT_CYC ((`JTDP_WAIT_NS * `JTDP_CLK_MHZ) / 1000)

// host: test-logic-reset walk length
`define JTDP_RST_TMS_ONES 5

`endif

// ---- jtdp_pkg.sv ----
package jtdp_pkg;

    // tap controller states
    typedef enum logic [3:0] {
        TAP_EX2DR = 4'b0000,
        TAP_EX1DR = 4'b0001,
        TAP_SHDR = 4'b0010,
        TAP_PSDR = 4'b0011,
        TAP_SELIR = 4'b0100,
        TAP_UPDR = 4'b0101,
        TAP_CAPDR = 4'b0110,
        TAP_SELDR = 4'b0111,
        TAP_EX2IR = 4'b1000,
        TAP_EX1IR = 4'b1001,
        TAP_SHIR = 4'b1010,
        TAP_PSIR = 4'b1011,
        TAP_RTI = 4'b1100,
        TAP_UPIR = 4'b1101,
        TAP_CAPIR = 4'b1110,
        TAP_TLR = 4'b1111
    } jtdp_tap_t;

    // host scan sequencer phases, each but HST_IDLE left at a test clock fall
    typedef enum logic [3:0] {
        HST_RST = 4'b0000,
        HST_IDLE = 4'b0001,
        HST_SEL = 4'b0010,
        HST_SELIR = 4'b0011,
        HST_CAP = 4'b0100,
        HST_ENT = 4'b0101,
        HST_SHIFT = 4'b0110,
        HST_UPD = 4'b0111,
        HST_RTI = 4'b1000
    } jtdp_hst_t;

endpackage

// ---- jtdp_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface jtdp_if;
    // test pins from the controller
    logic tck;
    logic tms;
    logic tdi;
    logic trst_b;
    // serial data out with its enable
    logic tdo;
    logic tdo_oe;
    // open-drain debug event, one driver pair per end
    logic dbg_dev_o;
    logic dbg_dev_oe;
    logic dbg_host_o;
    logic dbg_host_oe;
    // resolved wire levels
    logic tdo_line;
    logic debug_event_line;

    // undriven data out floats high, weak pull-up on debug event
    assign tdo_line = tdo_oe ? tdo : 1'b1;
    assign debug_event_line = ~((dbg_dev_oe & ~dbg_dev_o) | (dbg_host_oe & ~dbg_host_o));

    modport dev (
        input tck, tms, tdi, trst_b, debug_event_line,
        output tdo, tdo_oe, dbg_dev_o, dbg_dev_oe
    );

    modport host (
        input tdo_line, debug_event_line,
        output tck, tms, tdi, trst_b, dbg_host_o, dbg_host_oe
    );
endinterface

`default_nettype wire

// ---- jtdp_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "jtdp_params.svh"

// Notes on behaviour
// [R1] test clock paces all test logic and shifting
// [R2] data in sampled at rising test clock
// [R3] mode select sampled at rising edge, steers tap
// [R4] data out driven only in shift states
// [R5] data out changes only on falling edges
// [R6] low test reset forces tap reset, clockless
// [R7] system should pair test reset with chip reset
// [R8] no debugger: hold test reset grounded
// [R9] debug event open-drain, only pulled low
// [R10] external low on debug event enters debug
// [R11] device pulls debug event low as acknowledge
// [R12] tap follows standard sixteen-state sequence
module jtdp_dev #(
    parameter logic [31:0] ID_VALUE = 32'h0000_0001 // arbitrary identity value
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // pins toward the controller
    jtdp_if.dev pins,
    // chip side
    output logic dbg_mode,
    input wire logic dbg_resume,
    input wire logic [15:0] usr_cap_data,
    output logic [15:0] usr_upd_data,
    output logic usr_upd,
    output logic tap_reset,
    output logic [3:0] cur_ir
);

    // synchroniser stages: {trst_b, tck, tms, tdi, debug event}
    logic [4:0] s1_q, s1_d, s2_q, s2_d;
    logic tck_prev_q, tck_prev_d;
    logic s_trst_b, s_tck, s_tms, s_tdi, s_dbg;
    logic tck_rise, tck_fall;

    // tap state
    jtdp_pkg::jtdp_tap_t state_q, state_d;
    logic [3:0] ir_q, ir_d, ir_sr_q, ir_sr_d;
    logic [31:0] dr_sr_q, dr_sr_d;
    logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
    logic [15:0] upd_q, upd_d;
    logic upd_p_q, upd_p_d;
    logic dbgreq_q, dbgreq_d;

    // debug event state
    logic dbg_mode_q, dbg_mode_d;
    logic [7:0] ack_cnt_q, ack_cnt_d;
    logic [1:0] oe_hist_q, oe_hist_d;
    logic dbg_oe;
    logic dbg_enter;

    // standard tap transition on one rising edge
    function automatic jtdp_pkg::jtdp_tap_t tap_next(input jtdp_pkg::jtdp_tap_t s,
                                                     input logic m);
        jtdp_pkg::jtdp_tap_t n;
        n = jtdp_pkg::TAP_TLR;
        case (s)
            jtdp_pkg::TAP_TLR: n = m ? jtdp_pkg::TAP_TLR : jtdp_pkg::TAP_RTI;
            jtdp_pkg::TAP_RTI: n = m ? jtdp_pkg::TAP_SELDR : jtdp_pkg::TAP_RTI;
            jtdp_pkg::TAP_SELDR: n = m ? jtdp_pkg::TAP_SELIR : jtdp_pkg::TAP_CAPDR;
            jtdp_pkg::TAP_CAPDR: n = m ? jtdp_pkg::TAP_EX1DR : jtdp_pkg::TAP_SHDR;
            jtdp_pkg::TAP_SHDR: n = m ? jtdp_pkg::TAP_EX1DR : jtdp_pkg::TAP_SHDR;
            jtdp_pkg::TAP_EX1DR: n = m ? jtdp_pkg::TAP_UPDR : jtdp_pkg::TAP_PSDR;
            jtdp_pkg::TAP_PSDR: n = m ? jtdp_pkg::TAP_EX2DR : jtdp_pkg::TAP_PSDR;
            jtdp_pkg::TAP_EX2DR: n = m ? jtdp_pkg::TAP_UPDR : jtdp_pkg::TAP_SHDR;
            jtdp_pkg::TAP_UPDR: n = m ? jtdp_pkg::TAP_SELDR : jtdp_pkg::TAP_RTI;
            jtdp_pkg::TAP_SELIR: n = m ? jtdp_pkg::TAP_TLR : jtdp_pkg::TAP_CAPIR;
            jtdp_pkg::TAP_CAPIR: n = m ? jtdp_pkg::TAP_EX1IR : jtdp_pkg::TAP_SHIR;
            jtdp_pkg::TAP_SHIR: n = m ? jtdp_pkg::TAP_EX1IR : jtdp_pkg::TAP_SHIR;
            jtdp_pkg::TAP_EX1IR: n = m ? jtdp_pkg::TAP_UPIR : jtdp_pkg::TAP_PSIR;
            jtdp_pkg::TAP_PSIR: n = m ? jtdp_pkg::TAP_EX2IR : jtdp_pkg::TAP_PSIR;
            jtdp_pkg::TAP_EX2IR: n = m ? jtdp_pkg::TAP_UPIR : jtdp_pkg::TAP_SHIR;
            jtdp_pkg::TAP_UPIR: n = m ? jtdp_pkg::TAP_SELDR : jtdp_pkg::TAP_RTI;
            default: n = jtdp_pkg::TAP_TLR;
        endcase
        return n;
    endfunction

    // pin synchronisers and test clock edge finder
    always_comb begin
        s1_d = s1_q;
        s2_d = s2_q;
        tck_prev_d = tck_prev_q;
        if (ce) begin
            s1_d = {pins.trst_b, pins.tck, pins.tms, pins.tdi, pins.debug_event_line};
            s2_d = s1_q;
            tck_prev_d = s2_q[3];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 5'h17; // idle pin levels, tck low so no false edge
            s2_q <= 5'h17;
            tck_prev_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            tck_prev_q <= tck_prev_d;
        end
    end

    assign s_trst_b = s2_q[4];
    assign s_tck = s2_q[3];
    assign s_tms = s2_q[2];
    assign s_tdi = s2_q[1];
    assign s_dbg = s2_q[0];
    assign tck_rise = ce & s_tck & ~tck_prev_q; // [R1]
    assign tck_fall = ce & ~s_tck & tck_prev_q; // [R1]

    // tap controller, instruction and data paths
    always_comb begin
        state_d = state_q;
        ir_d = ir_q;
        ir_sr_d = ir_sr_q;
        dr_sr_d = dr_sr_q;
        tdo_d = tdo_q;
        tdo_oe_d = tdo_oe_q;
        upd_d = upd_q;
        upd_p_d = ce ? 1'b0 : upd_p_q;
        dbgreq_d = ce ? 1'b0 : dbgreq_q;
        if (ce && !s_trst_b) begin
            state_d = jtdp_pkg::TAP_TLR; // [R6]
            ir_d = `JTDP_IR_RESET;
            tdo_oe_d = 1'b0;
        end else if (tck_rise) begin
            state_d = tap_next(state_q, s_tms); // [R3] [R12]
            case (state_q)
                jtdp_pkg::TAP_SELIR: ir_d = s_tms ? `JTDP_IR_RESET : ir_q; // [R12]
                jtdp_pkg::TAP_CAPIR: ir_sr_d = `JTDP_IR_CAPTURE;
                jtdp_pkg::TAP_SHIR: ir_sr_d = {s_tdi, ir_sr_q[3:1]}; // [R2]
                jtdp_pkg::TAP_UPIR: ir_d = ir_sr_q;
                jtdp_pkg::TAP_CAPDR: begin
                    case (ir_q)
                        `JTDP_INS_IDCODE: dr_sr_d = ID_VALUE;
                        `JTDP_INS_USER: dr_sr_d = {16'h0000, usr_cap_data};
                        default: dr_sr_d = 32'h0000_0000;
                    endcase
                end
                jtdp_pkg::TAP_SHDR: begin
                    case (ir_q) // [R2]
                        `JTDP_INS_IDCODE: dr_sr_d = {s_tdi, dr_sr_q[31:1]};
                        `JTDP_INS_USER: dr_sr_d = {16'h0000, s_tdi, dr_sr_q[15:1]};
                        default: dr_sr_d = {31'h0000_0000, s_tdi};
                    endcase
                end
                jtdp_pkg::TAP_UPDR: begin
                    if (ir_q == `JTDP_INS_USER) begin
                        upd_d = dr_sr_q[15:0];
                        upd_p_d = 1'b1;
                    end
                    if (ir_q == `JTDP_INS_DBGREQ) begin
                        dbgreq_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            // output stage moves only here, its enable here and on test reset
            tdo_oe_d = (state_q == jtdp_pkg::TAP_SHIR) || (state_q == jtdp_pkg::TAP_SHDR); // [R4]
            if (state_q == jtdp_pkg::TAP_SHIR) begin
                tdo_d = ir_sr_q[0]; // [R5]
            end else if (state_q == jtdp_pkg::TAP_SHDR) begin
                tdo_d = dr_sr_q[0]; // [R5]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= jtdp_pkg::TAP_TLR;
            ir_q <= `JTDP_IR_RESET;
            ir_sr_q <= 4'h0;
            dr_sr_q <= 32'h0000_0000;
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
            upd_q <= 16'h0000;
            upd_p_q <= 1'b0;
            dbgreq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ir_q <= ir_d;
            ir_sr_q <= ir_sr_d;
            dr_sr_q <= dr_sr_d;
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
            upd_q <= upd_d;
            upd_p_q <= upd_p_d;
            dbgreq_q <= dbgreq_d;
        end
    end

    // entry ignores the line while our own pull may still echo back
    assign dbg_enter = (~s_dbg & (ack_cnt_q == 8'h00) & (oe_hist_q == 2'b00)) | dbgreq_q; // [R10]
    assign dbg_oe = (ack_cnt_q != 8'h00);

    // debug mode and acknowledge pull
    always_comb begin
        dbg_mode_d = dbg_mode_q;
        ack_cnt_d = ack_cnt_q;
        oe_hist_d = oe_hist_q;
        if (ce) begin
            oe_hist_d = {oe_hist_q[0], dbg_oe};
            if (ack_cnt_q != 8'h00) begin
                ack_cnt_d = ack_cnt_q - 8'h01;
            end
            if (dbg_mode_q && dbg_resume) begin
                dbg_mode_d = 1'b0;
            end else if (!dbg_mode_q && dbg_enter) begin
                dbg_mode_d = 1'b1; // [R10]
                ack_cnt_d = 8'(`JTDP_ACK_CYC); // [R11]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dbg_mode_q <= 1'b0;
            ack_cnt_q <= 8'h00;
            oe_hist_q <= 2'b00;
        end else begin
            dbg_mode_q <= dbg_mode_d;
            ack_cnt_q <= ack_cnt_d;
            oe_hist_q <= oe_hist_d;
        end
    end

    // pin and chip-side outputs
    assign pins.tdo = tdo_q;
    assign pins.tdo_oe = tdo_oe_q; // [R4]
    assign pins.dbg_dev_o = 1'b0; // [R9]
    assign pins.dbg_dev_oe = dbg_oe; // [R9] [R11]
    assign dbg_mode = dbg_mode_q;
    assign usr_upd_data = upd_q;
    assign usr_upd = upd_p_q;
    assign tap_reset = (state_q == jtdp_pkg::TAP_TLR);
    assign cur_ir = ir_q;

endmodule

`default_nettype wire

// ---- jtdp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "jtdp_params.svh"

module jtdp_host (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // pins toward the device
    jtdp_if.host pins,
    // scan request
    input wire logic scan_valid,
    output logic scan_ready,
    input wire logic scan_ir,
    input wire logic [5:0] scan_len,
    input wire logic [31:0] scan_din,
    // scan result
    output logic res_valid,
    output logic [31:0] res_dout,
    // resets and debug
    input wire logic trst_req,
    input wire logic tap_reset_req,
    input wire logic dbg_req,
    output logic dbg_ack,
    output logic dbg_timeout
);

    // synchronisers: {data out, debug event}
    logic [1:0] s1_q, s1_d, s2_q, s2_d;

    // scan sequencer and clock divider
    jtdp_pkg::jtdp_hst_t hst_q, hst_d;
    logic [7:0] div_q, div_d;
    logic tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d, trst_b_q, trst_b_d;
    logic [5:0] cnt_q, cnt_d, len_q, len_d;
    logic ir_q, ir_d;
    logic [31:0] din_q, din_d, sr_q, sr_d, dout_q, dout_d;
    logic rv_q, rv_d;
    logic tick;

    // debug request engine
    logic [7:0] pull_q, pull_d, wait_q, wait_d;
    logic ack_q, ack_d, tmo_q, tmo_d;

    assign tick = (div_q == 8'(`JTDP_TCK_HALF_CYC - 1));
    assign scan_ready = ce & (hst_q == jtdp_pkg::HST_IDLE);

    // pin synchronisers
    always_comb begin
        s1_d = ce ? {pins.tdo_line, pins.debug_event_line} : s1_q;
        s2_d = ce ? s1_q : s2_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 2'b11;
            s2_q <= 2'b11;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    // test clock generation and tms walk, tms and tdi move only at falls, tms also on leaving HST_IDLE
    always_comb begin
        hst_d = hst_q;
        div_d = div_q;
        tck_d = tck_q;
        tms_d = tms_q;
        tdi_d = tdi_q;
        trst_b_d = ce ? ~trst_req : trst_b_q;
        cnt_d = cnt_q;
        len_d = len_q;
        ir_d = ir_q;
        din_d = din_q;
        sr_d = sr_q;
        dout_d = dout_q;
        rv_d = ce ? 1'b0 : rv_q;
        if (ce && hst_q == jtdp_pkg::HST_IDLE) begin
            div_d = 8'h00;
            if (scan_valid) begin
                hst_d = jtdp_pkg::HST_SEL;
                tms_d = 1'b1;
                len_d = scan_len;
                ir_d = scan_ir;
                din_d = scan_din;
                sr_d = 32'h0000_0000;
                cnt_d = 6'h00;
            end else if (tap_reset_req) begin
                hst_d = jtdp_pkg::HST_RST;
                tms_d = 1'b1;
                cnt_d = 6'h00;
            end
        end else if (ce) begin
            div_d = tick ? 8'h00 : div_q + 8'h01;
            if (tick && !tck_q) begin
                tck_d = 1'b1;
                if (hst_q == jtdp_pkg::HST_SHIFT) begin
                    sr_d[cnt_q[4:0]] = s2_q[1];
                end
            end else if (tick) begin
                tck_d = 1'b0;
                case (hst_q)
                    jtdp_pkg::HST_RST: begin
                        if (cnt_q == 6'(`JTDP_RST_TMS_ONES - 1)) begin
                            hst_d = jtdp_pkg::HST_RTI;
                            tms_d = 1'b0;
                        end else begin
                            cnt_d = cnt_q + 6'h01;
                        end
                    end
                    jtdp_pkg::HST_SEL: begin
                        hst_d = ir_q ? jtdp_pkg::HST_SELIR : jtdp_pkg::HST_CAP;
                        tms_d = ir_q;
                    end
                    jtdp_pkg::HST_SELIR: begin
                        hst_d = jtdp_pkg::HST_CAP;
                        tms_d = 1'b0;
                    end
                    jtdp_pkg::HST_CAP: hst_d = jtdp_pkg::HST_ENT;
                    jtdp_pkg::HST_ENT: begin
                        hst_d = jtdp_pkg::HST_SHIFT;
                        tms_d = (len_q == 6'h01);
                        tdi_d = din_q[0];
                    end
                    jtdp_pkg::HST_SHIFT: begin
                        if (cnt_q == len_q - 6'h01) begin
                            hst_d = jtdp_pkg::HST_UPD;
                            tms_d = 1'b1;
                        end else begin
                            cnt_d = cnt_q + 6'h01;
                            tms_d = (cnt_q + 6'h02 == len_q);
                            tdi_d = din_q[5'(cnt_q + 6'h01)];
                        end
                    end
                    jtdp_pkg::HST_UPD: begin
                        hst_d = jtdp_pkg::HST_RTI;
                        tms_d = 1'b0;
                    end
                    jtdp_pkg::HST_RTI: begin
                        hst_d = jtdp_pkg::HST_IDLE;
                        dout_d = sr_q;
                        rv_d = (cnt_q != 6'(`JTDP_RST_TMS_ONES - 1)) || (len_q != 6'h00);
                        len_d = 6'h00;
                    end
                    default: hst_d = jtdp_pkg::HST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hst_q <= jtdp_pkg::HST_RST;
            div_q <= 8'h00;
            tck_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b1;
            trst_b_q <= 1'b1;
            cnt_q <= 6'h00;
            len_q <= 6'h00;
            ir_q <= 1'b0;
            din_q <= 32'h0000_0000;
            sr_q <= 32'h0000_0000;
            dout_q <= 32'h0000_0000;
            rv_q <= 1'b0;
        end else begin
            hst_q <= hst_d;
            div_q <= div_d;
            tck_q <= tck_d;
            tms_q <= tms_d;
            tdi_q <= tdi_d;
            trst_b_q <= trst_b_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            ir_q <= ir_d;
            din_q <= din_d;
            sr_q <= sr_d;
            dout_q <= dout_d;
            rv_q <= rv_d;
        end
    end

    // debug request pull, then watch for the device acknowledge
    always_comb begin
        pull_d = pull_q;
        wait_d = wait_q;
        ack_d = ce ? 1'b0 : ack_q;
        tmo_d = ce ? 1'b0 : tmo_q;
        if (ce) begin
            if (pull_q != 8'h00) begin
                pull_d = pull_q - 8'h01;
                if (pull_q == 8'h01) begin
                    wait_d = 8'(`JTDP_WAIT_CYC);
                end
            end else if (wait_q != 8'h00) begin
                wait_d = wait_q - 8'h01;
                if (wait_q <= 8'(`JTDP_WAIT_CYC - `JTDP_GUARD_CYC) && !s2_q[0]) begin
                    ack_d = 1'b1;
                    wait_d = 8'h00;
                end else if (wait_q == 8'h01) begin
                    tmo_d = 1'b1;
                end
            end else if (dbg_req) begin
                pull_d = 8'(`JTDP_REQ_CYC);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_q <= 8'h00;
            wait_q <= 8'h00;
            ack_q <= 1'b0;
            tmo_q <= 1'b0;
        end else begin
            pull_q <= pull_d;
            wait_q <= wait_d;
            ack_q <= ack_d;
            tmo_q <= tmo_d;
        end
    end

    // pin and user outputs
    assign pins.tck = tck_q;
    assign pins.tms = tms_q;
    assign pins.tdi = tdi_q;
    assign pins.trst_b = trst_b_q;
    assign pins.dbg_host_o = 1'b0;
    assign pins.dbg_host_oe = (pull_q != 8'h00);
    assign res_valid = rv_q;
    assign res_dout = dout_q;
    assign dbg_ack = ack_q;
    assign dbg_timeout = tmo_q;

endmodule

`default_nettype wire

// ---- jtdp_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module jtdp_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_b,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic dbg_dev_o,
    input wire logic dbg_dev_oe,
    input wire logic dbg_host_o,
    input wire logic dbg_host_oe,
    input wire logic debug_event_line
);
    logic [6:0] pull_cnt_q;
    logic [6:0] pull_cnt_d;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // length of the current device pull
    always_comb begin
        pull_cnt_d = dbg_dev_oe ? pull_cnt_q + 7'h01 : 7'h00;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_cnt_q <= 7'h00;
        end else begin
            pull_cnt_q <= pull_cnt_d;
        end
    end

    // link timing and open-drain checks
    a_tck_half_period: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
        else $error("test clock high phase wrong");
    a_tms_held: assert property ($rose(tck) |-> $stable(tms) [*4])
        else $error("mode select moved near rising edge");
    a_tdi_held: assert property ($rose(tck) |-> $stable(tdi) [*4])
        else $error("data in moved near rising edge");
    a_tdo_fall_only: assert property (tdo_oe && $past(tdo_oe) && $changed(tdo) |-> !tck)
        else $error("data out changed while test clock high");
    a_oe_on_fall: assert property ($rose(tdo_oe) |-> !tck)
        else $error("data out enabled off a falling edge");
    a_trst_quiets_tdo: assert property (!trst_b [*4] |-> !tdo_oe)
        else $error("data out driven during test reset");
    a_dev_pull_only: assert property (dbg_dev_oe |-> !dbg_dev_o && !debug_event_line)
        else $error("device drives debug line high");
    a_host_pull_only: assert property (dbg_host_oe |-> !dbg_host_o)
        else $error("controller drives debug line high");
    a_ack_after_req: assert property ($rose(dbg_dev_oe) |-> dbg_host_oe)
        else $error("acknowledge without request");
    a_ack_pull_len: assert property ($fell(dbg_dev_oe) |-> pull_cnt_q == 7'h40)
        else $error("acknowledge pull length wrong");

    // main scenarios
    c_shift: cover property ($rose(tdo_oe));
    c_ack: cover property ($rose(dbg_dev_oe));
    c_trst: cover property ($fell(trst_b));
endmodule

`default_nettype wire

// ---- jtdp_debug_pin_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module jtag_debug_pin_port_bench;
    localparam logic [31:0] ID_WORD = 32'h1357_9BDF; // arbitrary identity value
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic scan_valid = 1'b0;
    logic scan_ir = 1'b0;
    logic [5:0] scan_len = 6'h01;
    logic [31:0] scan_din = 32'h0;
    logic trst_req = 1'b0;
    logic tap_reset_req = 1'b0;
    logic dbg_req = 1'b0;
    logic dbg_resume = 1'b0;
    logic [15:0] usr_cap_data = 16'h1234;
    logic scan_ready, res_valid, dbg_ack, dbg_timeout, dbg_mode, usr_upd, tap_reset;
    logic [31:0] res_dout;
    logic [15:0] usr_upd_data;
    logic [3:0] cur_ir;
    int upd_count = 0;
    int upd_base = 0;
    int num_errors = 0;
    int checked = 0;
    int n;

    jtdp_if jtdp_if_inst ();

    jtdp_dev #(.ID_VALUE(ID_WORD)) jtdp_dev_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .pins(jtdp_if_inst), .dbg_mode(dbg_mode), .dbg_resume(dbg_resume),
        .usr_cap_data(usr_cap_data), .usr_upd_data(usr_upd_data), .usr_upd(usr_upd),
        .tap_reset(tap_reset), .cur_ir(cur_ir));

    jtdp_host jtdp_host_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1), .pins(jtdp_if_inst),
        .scan_valid(scan_valid), .scan_ready(scan_ready), .scan_ir(scan_ir),
        .scan_len(scan_len), .scan_din(scan_din), .res_valid(res_valid), .res_dout(res_dout),
        .trst_req(trst_req), .tap_reset_req(tap_reset_req), .dbg_req(dbg_req),
        .dbg_ack(dbg_ack), .dbg_timeout(dbg_timeout));

    jtdp_monitor jtdp_monitor_inst (.clk(clk), .rst_b(rst_b), .tck(jtdp_if_inst.tck),
        .tms(jtdp_if_inst.tms), .tdi(jtdp_if_inst.tdi), .trst_b(jtdp_if_inst.trst_b),
        .tdo(jtdp_if_inst.tdo), .tdo_oe(jtdp_if_inst.tdo_oe),
        .dbg_dev_o(jtdp_if_inst.dbg_dev_o), .dbg_dev_oe(jtdp_if_inst.dbg_dev_oe),
        .dbg_host_o(jtdp_if_inst.dbg_host_o), .dbg_host_oe(jtdp_if_inst.dbg_host_oe),
        .debug_event_line(jtdp_if_inst.debug_event_line));

    // clock and update pulse catcher
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (usr_upd === 1'b1) begin
            upd_count <= upd_count + 1;
        end
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic expire(input int lim);
        if (n >= lim) begin
            num_errors++;
            $display("MISMATCH %0t wait ran out", $time);
            close_out();
        end
    endtask

    // one ir or dr scan through the controller end
    task automatic scan(input logic ir, input logic [5:0] len, input logic [31:0] din);
        for (n = 0; scan_ready !== 1'b1 && n < 500; n++) tick();
        expire(500);
        scan_valid = 1'b1;
        scan_ir = ir;
        scan_len = len;
        scan_din = din;
        tick();
        scan_valid = 1'b0;
        for (n = 0; res_valid !== 1'b1 && n < 1500; n++) tick();
        expire(1500);
    endtask

    // tap reset walk, then wait for the device to report it
    task automatic walk_reset();
        tap_reset_req = 1'b1;
        tick();
        tap_reset_req = 1'b0;
        for (n = 0; tap_reset !== 1'b1 && n < 300; n++) tick();
        expire(300);
    endtask

    // one debug request, ends on acknowledge or timeout
    task automatic dbg_try();
        dbg_req = 1'b1;
        tick();
        dbg_req = 1'b0;
        for (n = 0; dbg_ack !== 1'b1 && dbg_timeout !== 1'b1 && n < 300; n++) tick();
        expire(300);
    endtask

    task automatic t_idcode();
        scan(1'b0, 6'h20, 32'h0);
        check(res_dout, ID_WORD);
        check({31'h0, jtdp_if_inst.tdo_line}, 32'h1);
    endtask

    task automatic t_bypass();
        scan(1'b1, 6'h04, 32'hF);
        check(res_dout, 32'h1);
        check({28'h0, cur_ir}, 32'hF);
        scan(1'b0, 6'h08, 32'hA5);
        check(res_dout, 32'h4A);
    endtask

    task automatic t_user();
        scan(1'b1, 6'h04, 32'h8);
        upd_base = upd_count;
        scan(1'b0, 6'h10, 32'hBEEF);
        check(res_dout, 32'h1234);
        check({16'h0, usr_upd_data}, 32'hBEEF);
        check(32'(upd_count - upd_base), 32'h1);
    endtask

    task automatic t_resets();
        scan(1'b1, 6'h04, 32'h8);
        trst_req = 1'b1;
        for (n = 0; tap_reset !== 1'b1 && n < 20; n++) tick();
        expire(20);
        repeat (6) tick();
        check({28'h0, cur_ir}, 32'h2);
        check({31'h0, jtdp_if_inst.tdo_oe}, 32'h0);
        trst_req = 1'b0;
        walk_reset();
        scan(1'b1, 6'h04, 32'h8);
        check({28'h0, cur_ir}, 32'h8);
        walk_reset();
        check({28'h0, cur_ir}, 32'h2);
    endtask

    task automatic t_debug();
        dbg_try();
        check({30'h0, dbg_ack, dbg_mode}, 32'h3);
        for (n = 0; jtdp_if_inst.debug_event_line !== 1'b1 && n < 100; n++) tick();
        expire(100);
        dbg_try();
        check({30'h0, dbg_timeout, dbg_ack}, 32'h2);
        dbg_resume = 1'b1;
        tick();
        dbg_resume = 1'b0;
        tick();
        check({31'h0, dbg_mode}, 32'h0);
        dbg_try();
        check({30'h0, dbg_ack, dbg_mode}, 32'h3);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_idcode();
        t_bypass();
        t_user();
        t_resets();
        t_debug();
        close_out();
    end
endmodule

`default_nettype wire
